// ---- hw/interlock_teach_and_lock_ctrl.sv ----
`timescale 1ns/1ps
module interlock_teach_and_lock_ctrl
   import interlock_pkg::*;
#(
   parameter int TICK_LEN      = TICK_CYCLES,
   parameter int TEACH_RUN_LEN = TEACH_RUN_TICKS,
   parameter int POWEROFF_LEN  = POWEROFF_TICKS,
   parameter int INHIBIT_LEN   = INHIBIT_TICKS
) (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins from the field
   input  wire logic        supply_ok,
   input  wire logic        actuator_detect,
   input  wire logic [15:0] actuator_code,
   input  wire logic        guard_closed,
   input  wire logic        selector_ok,
   input  wire logic        solenoid_cmd,
   // Actuation and safety outputs
   output logic             solenoid_energize,
   output logic             lock_engaged,
   output logic             safety_output_first,
   output logic             safety_output_second,
   // Indicators
   output logic             led_green,
   output logic             led_red,
   output logic             led_yellow,
   // Interrupt
   output logic             irq
);

   localparam logic [19:0] RUN_LAST = 20'(TEACH_RUN_LEN - 1);
   localparam logic [19:0] OFF_LAST = 20'(POWEROFF_LEN - 1);
   localparam logic [19:0] INH_LAST = 20'(INHIBIT_LEN - 1);

   // Synchronised pins
   logic [20:0]     sync_out;
   wire             s_supply   = sync_out[0];
   wire             s_detect   = sync_out[1];
   wire             s_guard    = sync_out[2];
   wire             s_selector = sync_out[3];
   wire             s_cmd      = sync_out[4];
   wire [15:0]      s_code     = sync_out[20:5];
   logic            tick;

   // State
   teach_state_t    state;          // Pairing sequence
   teach_state_t    next_state;
   logic [19:0]     phase_cnt;      // Ticks in current state
   logic            supply_q;       // Previous supply level
   logic            fresh_power;    // No actuator seen since power-up
   logic [15:0]     pending_code;   // Code under pairing
   logic [15:0]     learned_code;   // Active individual code
   logic            learned;        // An individual code is held
   logic            inhibit_active; // Enabling inhibit running
   logic [19:0]     inhibit_cnt;    // Inhibit ticks elapsed

   // Blink phase counters
   logic [9:0]      slow_cnt;
   logic [8:0]      fast_cnt;
   logic [8:0]      code_sub;
   logic [2:0]      code_slot;

   // Registers
   logic [3:0]      config_reg;
   logic [4:0]      status;
   logic [4:0]      enable;
   logic            refused_q;

   // Pin synchroniser
   input_sync #(.WIDTH(21)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .raw     ({actuator_code, solenoid_cmd, selector_ok, guard_closed, actuator_detect, supply_ok}),
      .stable  (sync_out)
   );

   // Common timebase
   tick_gen #(.CYCLES(TICK_LEN)) u_tick (
      .clk_sys (clk_sys),
      .rst     (rst),
      .tick    (tick)
   );

   // Configuration fields
   wire cfg_individual = config_reg[CFG_INDIVIDUAL];
   wire cfg_repeatable = config_reg[CFG_REPEATABLE];
   wire cfg_p2lock     = config_reg[CFG_POWER_TO_LOCK];
   wire cfg_door_dep   = config_reg[CFG_DOOR_DEPENDENT];

   // Actuator qualification
   wire code_std   = (s_code == STANDARD_CODE);
   wire code_own   = learned && (s_code == learned_code);
   wire code_valid = cfg_individual ? code_own : code_std;
   wire power_rise = s_supply && !supply_q;
   wire present    = s_supply && s_detect;

   // Pairing entry: fresh power, unknown actuator, variant allows it
   wire may_pair    = cfg_repeatable || !learned;
   wire teach_start = (state == ST_NORMAL) && present && fresh_power
                      && cfg_individual && !code_valid && may_pair;
   wire run_done    = tick && (phase_cnt == RUN_LAST);
   wire off_timeout = tick && (phase_cnt == OFF_LAST);
   wire learn_now   = (state == ST_CONFIRM) && present && (s_code == pending_code);
   wire confirm_bad = (state == ST_CONFIRM) && present && (s_code != pending_code);
   wire inhibit_done = (inhibit_cnt == INH_LAST);

   // Sequence transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_NORMAL: begin
            if (teach_start)
               next_state = ST_PAIRING;
         end
         ST_PAIRING: begin
            // Early power loss or removal cancels
            if (!present)
               next_state = ST_NORMAL;
            else if (run_done)
               next_state = ST_OFF_REQ;
         end
         ST_OFF_REQ: begin
            if (!s_supply)
               next_state = ST_CONFIRM;
            else if (off_timeout)
               next_state = ST_ABORTED;
         end
         ST_CONFIRM: begin
            if (learn_now)
               next_state = ST_NORMAL;
            else if (confirm_bad)
               next_state = ST_ABORTED;
         end
         ST_ABORTED: begin
            // Held until the next power cycle
            if (!s_supply)
               next_state = ST_NORMAL;
         end
         default: begin
            next_state = ST_NORMAL;
         end
      endcase
   end

   // State register and phase count
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state     <= ST_NORMAL;
         phase_cnt <= 20'h00000;
      end else begin
         state <= next_state;
         if (next_state != state)
            phase_cnt <= 20'h00000;
         else if (tick)
            phase_cnt <= phase_cnt + 20'h00001;
      end
   end

   // Power-up tracking
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         supply_q    <= 1'b0;
         fresh_power <= 1'b1;
      end else begin
         supply_q <= s_supply;
         if (power_rise)
            fresh_power <= 1'b1;
         else if (present)
            fresh_power <= 1'b0;
      end
   end

   // Code storage; a new code replaces the old one
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pending_code <= CODE_RESET;
         learned_code <= CODE_RESET;
         learned      <= 1'b0;
      end else begin
         if (teach_start)
            pending_code <= s_code;
         if (learn_now) begin
            learned_code <= pending_code;
            learned      <= 1'b1;
         end
      end
   end

   // Enabling inhibit after learning
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         inhibit_active <= 1'b0;
         inhibit_cnt    <= 20'h00000;
      end else if (learn_now) begin
         inhibit_active <= 1'b1;
         inhibit_cnt    <= 20'h00000;
      end else if (inhibit_active) begin
         if (!s_supply)
            inhibit_cnt <= 20'h00000;
         else if (tick && !inhibit_done)
            inhibit_cnt <= inhibit_cnt + 20'h00001;
         if (inhibit_done && present && code_valid)
            inhibit_active <= 1'b0;
      end
   end

   // Lock and safety output decisions
   wire actuator_ok = present && code_valid && (state == ST_NORMAL);
   wire lock_req    = cfg_p2lock ? s_cmd : !s_cmd;
   wire next_lock   = lock_req && s_guard && s_selector && actuator_ok;
   wire refused     = lock_req && s_guard && actuator_ok && !s_selector;
   wire lock_ok     = cfg_door_dep || next_lock;
   wire next_safe   = actuator_ok && s_guard && !inhibit_active && lock_ok;

   // Actuator and safety outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         solenoid_energize    <= 1'b0;
         lock_engaged         <= 1'b0;
         safety_output_first  <= 1'b0;
         safety_output_second <= 1'b0;
         refused_q            <= 1'b0;
      end else begin
         solenoid_energize    <= s_supply && s_cmd;
         lock_engaged         <= next_lock;
         safety_output_first  <= next_safe;
         safety_output_second <= next_safe;
         refused_q            <= refused;
      end
   end

   // Blink phase counters on the tick
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         slow_cnt  <= 10'h000;
         fast_cnt  <= 9'h000;
         code_sub  <= 9'h000;
         code_slot <= 3'h0;
      end else if (tick) begin
         slow_cnt <= (slow_cnt == SLOW_LAST) ? 10'h000 : slow_cnt + 10'h001;
         fast_cnt <= (fast_cnt == FAST_LAST) ? 9'h000 : fast_cnt + 9'h001;
         code_sub <= (code_sub == CODE_LAST) ? 9'h000 : code_sub + 9'h001;
         if (code_sub == CODE_LAST)
            code_slot <= (code_slot == CODE_SLOT_LAST) ? 3'h0 : code_slot + 3'h1;
      end
   end

   // Blink patterns
   wire blink_slow = (slow_cnt < SLOW_ON);
   wire blink_fast = (fast_cnt < FAST_ON);
   wire blink_code = (code_slot < CODE_FLASHES) && (code_sub < CODE_ON);

   // Indicator selection
   logic next_green, next_red, next_yellow;   // Indicator levels before the flops
   always_comb begin
      next_green  = 1'b0;
      next_red    = 1'b0;
      next_yellow = 1'b0;
      if (s_supply) begin
         case (state)
            ST_PAIRING: begin
               next_red    = 1'b1;
               next_yellow = blink_slow;
            end
            ST_OFF_REQ: begin
               next_red    = 1'b1;
               next_yellow = blink_fast;
            end
            ST_CONFIRM: begin
               next_red    = 1'b1;
            end
            ST_ABORTED: begin
               next_red    = blink_code;
            end
            default: begin
               next_green  = inhibit_active ? blink_slow : 1'b1;
               next_yellow = next_lock || (s_guard && blink_slow);
            end
         endcase
      end
   end

   // Indicator flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         led_green  <= 1'b0;
         led_red    <= 1'b0;
         led_yellow <= 1'b0;
      end else begin
         led_green  <= next_green;
         led_red    <= next_red;
         led_yellow <= next_yellow;
      end
   end

   // Events feeding sticky status
   wire [4:0] events;
   assign events[EV_TEACH_START]  = teach_start;
   assign events[EV_LEARNED]      = learn_now;
   assign events[EV_ABORTED]      = (next_state == ST_ABORTED) && (state != ST_ABORTED);
   assign events[EV_OUTPUTS_OFF]  = safety_output_first && !next_safe;
   assign events[EV_LOCK_REFUSED] = refused && !refused_q;

   // APB decode
   wire setup     = psel && !penable;
   wire access_wr = psel && penable && pwrite && pready;
   wire hit_cfg   = (paddr == REG_CONFIG);
   wire hit_stat  = (paddr == REG_STATUS);
   wire hit_clr   = (paddr == REG_CLEAR);
   wire hit_en    = (paddr == REG_ENABLE);
   wire hit_code  = (paddr == REG_CODE);
   wire hit_state = (paddr == REG_STATE);
   wire mapped    = hit_cfg || hit_stat || hit_clr || hit_en || hit_code || hit_state;
   wire [4:0] clr_mask = (access_wr && hit_clr) ? pwdata[4:0] : 5'h00;

   // Read data selection
   wire [31:0] read_word = hit_cfg   ? {28'h0000000, config_reg} :
                           hit_stat  ? {27'h0000000, status} :
                           hit_en    ? {27'h0000000, enable} :
                           hit_code  ? {15'h0000, learned, learned_code} :
                           hit_state ? {26'h0000000, s_guard, s_detect, inhibit_active, state} :
                           32'h00000000;
   // Set wins over clear
   wire [4:0] next_status = (status & ~clr_mask) | events;

   // Register writes and status
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         config_reg <= CFG_RESET;
         enable     <= EV_RESET;
         status     <= EV_RESET;
         irq        <= 1'b0;
      end else begin
         if (access_wr && hit_cfg)
            config_reg <= pwdata[3:0];
         if (access_wr && hit_en)
            enable <= pwdata[4:0];
         status <= next_status;
         irq    <= |(next_status & enable);
      end
   end

   // Zero-wait answer in the access phase
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup)
            prdata <= pwrite ? 32'h00000000 : read_word;
      end
   end

endmodule

// ---- hw/interlock_pkg.sv ----
package interlock_pkg;

   // Register byte offsets
   localparam logic [7:0] REG_CONFIG  = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_CLEAR   = 8'h08;
   localparam logic [7:0] REG_ENABLE  = 8'h0c;
   localparam logic [7:0] REG_CODE    = 8'h10;
   localparam logic [7:0] REG_STATE   = 8'h14;

   // Configuration fields
   localparam int         CFG_WIDTH          = 4;
   localparam int         CFG_INDIVIDUAL     = 0;
   localparam int         CFG_REPEATABLE     = 1;
   localparam int         CFG_POWER_TO_LOCK  = 2;
   localparam int         CFG_DOOR_DEPENDENT = 3;
   localparam logic [3:0] CFG_RESET          = 4'h0;

   // Event bits of status, clear and enable
   localparam int         EV_WIDTH        = 5;
   localparam int         EV_TEACH_START  = 0;
   localparam int         EV_LEARNED      = 1;
   localparam int         EV_ABORTED      = 2;
   localparam int         EV_OUTPUTS_OFF  = 3;
   localparam int         EV_LOCK_REFUSED = 4;
   localparam logic [4:0] EV_RESET        = 5'h00;

   // Actuator code; the standard value is arbitrary
   localparam int          CODE_WIDTH    = 16;
   localparam logic [15:0] STANDARD_CODE = 16'h5a5a;
   localparam logic [15:0] CODE_RESET    = 16'h0000;

   // Tick timing
   localparam int CLK_HZ        = 20_000_000;
   localparam int TICK_US       = 1000;
   localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
   localparam int TICKS_PER_S   = 1_000_000 / TICK_US;
   localparam int TICKS_WIDTH   = 20;

   // Pairing and inhibit times
   localparam int TEACH_RUN_S    = 10;
   localparam int POWEROFF_MIN   = 5;
   localparam int INHIBIT_MIN    = 10;
   localparam int TEACH_RUN_TICKS = TEACH_RUN_S * TICKS_PER_S;
   localparam int POWEROFF_TICKS  = POWEROFF_MIN * 60 * TICKS_PER_S;
   localparam int INHIBIT_TICKS   = INHIBIT_MIN * 60 * TICKS_PER_S;

   // Indicator patterns, in ticks
   localparam logic [9:0] SLOW_LAST = 10'h3e7;
   localparam logic [9:0] SLOW_ON   = 10'h1f4;
   localparam logic [8:0] FAST_LAST = 9'h14c;
   localparam logic [8:0] FAST_ON   = 9'h050;
   localparam logic [8:0] CODE_LAST = 9'h18f;
   localparam logic [8:0] CODE_ON   = 9'h0c8;
   localparam logic [2:0] CODE_SLOT_LAST = 3'h6;
   localparam logic [2:0] CODE_FLASHES   = 3'h5;

   // Pairing sequence states
   typedef enum logic [2:0] {
      ST_NORMAL   = 3'b000,
      ST_PAIRING  = 3'b001,
      ST_OFF_REQ  = 3'b011,
      ST_CONFIRM  = 3'b010,
      ST_ABORTED  = 3'b110
   } teach_state_t;

endpackage

// ---- hw/input_sync.sv ----
`timescale 1ns/1ps
module input_sync
   import interlock_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // Raw pins and synchronised copy
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] stable
);

   logic [WIDTH-1:0] meta;   // First stage, read only by second

   // Two flops per bit
   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               meta[i]   <= 1'b0;
               stable[i] <= 1'b0;
            end else begin
               meta[i]   <= raw[i];
               stable[i] <= meta[i];
            end
         end
      end
   endgenerate

endmodule

// ---- hw/tick_gen.sv ----
`timescale 1ns/1ps
module tick_gen
   import interlock_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst,
   // One-cycle tick
   output logic      tick
);

   localparam logic [15:0] LAST = 16'(CYCLES - 1);

   logic [15:0] count;   // Prescaler count
   wire         wrap = (count == LAST);

   // Prescaler, one pulse per period
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count <= 16'h0000;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? 16'h0000 : count + 16'h0001;
         tick  <= wrap;
      end
   end

endmodule

// ---- tb/interlock_teach_and_lock_ctrl_sva.sv ----
`timescale 1ns/1ps
module interlock_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Bus handshake
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   // Field pins
   input wire logic supply_ok,
   input wire logic actuator_detect,
   input wire logic guard_closed,
   input wire logic selector_ok,
   input wire logic solenoid_cmd,
   // Outputs under watch
   input wire logic solenoid_energize,
   input wire logic lock_engaged,
   input wire logic safety_output_first,
   input wire logic safety_output_second,
   input wire logic led_green,
   input wire logic led_red,
   input wire logic led_yellow
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Cycles since reset, saturating
   logic [2:0] up_cnt;
   // Counts up so history checks skip reset
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         up_cnt <= 3'h0;
      end else if (up_cnt != 3'h7) begin
         up_cnt <= up_cnt + 3'h1;
      end
   end
   // Setup phase, then one-cycle answer
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence
   a_ready_once: assert property (setup_s |=> answer_s)
      else $error("ready not a single cycle after setup");
   a_energize_cmd: assert property (up_cnt == 3'h7 |->
      solenoid_energize == $past(supply_ok && solenoid_cmd, 3))
      else $error("solenoid drive not following command");
   a_channels_equal: assert property (safety_output_first == safety_output_second)
      else $error("safety channels differ");
   a_open_outputs_off: assert property (!guard_closed [*5] |-> !safety_output_first)
      else $error("safety output on with guard open");
   a_open_no_lock: assert property (!guard_closed [*5] |-> !lock_engaged)
      else $error("lock engaged with guard open");
   a_selector_no_lock: assert property (!selector_ok [*5] |-> !lock_engaged)
      else $error("lock engaged with selector between positions");
   a_absent_outputs_off: assert property (!actuator_detect [*5] |-> !safety_output_second)
      else $error("safety output on without actuator");
   a_supply_dark: assert property (!supply_ok [*5] |->
      !(led_green || led_red || led_yellow || solenoid_energize))
      else $error("outputs active without supply");
endmodule
bind interlock_teach_and_lock_ctrl interlock_checker checker_i (
   .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
   .supply_ok(supply_ok), .actuator_detect(actuator_detect), .guard_closed(guard_closed),
   .selector_ok(selector_ok), .solenoid_cmd(solenoid_cmd), .solenoid_energize(solenoid_energize),
   .lock_engaged(lock_engaged), .safety_output_first(safety_output_first),
   .safety_output_second(safety_output_second), .led_green(led_green), .led_red(led_red),
   .led_yellow(led_yellow)
);

// ---- tb/field_partner.sv ----
`timescale 1ns/1ps
module field_partner (
   // Clock
   input  wire logic clk_sys,
   // Controller intent and solenoid polarity
   input  wire logic want_open,
   input  wire logic power_to_lock,
   output logic      solenoid_cmd,
   // Dual-channel monitor
   input  wire logic safety_output_first,
   input  wire logic safety_output_second,
   output logic      channels_differ
);
   // Command level for the fitted solenoid polarity
   assign solenoid_cmd = want_open ^ power_to_lock;
   // Sticky discrepancy flag of the monitor
   initial channels_differ = 1'h0;
   always @(posedge clk_sys) begin
      if (safety_output_first !== safety_output_second) begin
         channels_differ <= 1'h1;
      end
   end
endmodule

// ---- tb/interlock_teach_and_lock_ctrl_test.sv ----
`timescale 1ns/1ps
module interlock_teach_and_lock_ctrl_test
   import interlock_pkg::*;
;
   localparam int TK    = 4;     // Cycles per tick
   localparam int TR    = 20;    // Pairing run ticks
   localparam int PO    = 40;    // Power-off wait ticks
   localparam int IH    = 30;    // Inhibit ticks
   localparam int LIMIT = 20000; // Run ceiling
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        supply_ok, actuator_detect, guard_closed, selector_ok;
   logic [15:0] actuator_code;
   logic        want_open, power_to_lock, solenoid_cmd, channels_differ;
   logic        solenoid_energize, lock_engaged, safety_output_first, safety_output_second;
   logic        led_green, led_red, led_yellow, irq;
   int          failures = 0, cmp_count = 0, cyc = 0;
   interlock_teach_and_lock_ctrl #(
      .TICK_LEN(TK), .TEACH_RUN_LEN(TR), .POWEROFF_LEN(PO), .INHIBIT_LEN(IH)
   ) DUT (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .supply_ok(supply_ok), .actuator_detect(actuator_detect), .actuator_code(actuator_code),
      .guard_closed(guard_closed), .selector_ok(selector_ok), .solenoid_cmd(solenoid_cmd),
      .solenoid_energize(solenoid_energize), .lock_engaged(lock_engaged),
      .safety_output_first(safety_output_first), .safety_output_second(safety_output_second),
      .led_green(led_green), .led_red(led_red), .led_yellow(led_yellow), .irq(irq)
   );
   field_partner partner (
      .clk_sys(clk_sys), .want_open(want_open), .power_to_lock(power_to_lock),
      .solenoid_cmd(solenoid_cmd), .safety_output_first(safety_output_first),
      .safety_output_second(safety_output_second), .channels_differ(channels_differ)
   );
   // Clock at 50 ns period
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Counts and verdict, then stop
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         failures++;
         print_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wcyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // One bus transfer, held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge clk_sys);
      psel    <= 1'h1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        err;
      apb(1'h1, a, d, q, err);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
      logic [31:0] q;
      logic        err;
      apb(1'h0, a, 32'h0, q, err);
      chk(nm, e, q);
      chk(nm, {31'h0, ee}, {31'h0, err});
   endtask
   // Lock, safety, drive, green, red
   task automatic pins(input string nm, input logic [4:0] e);
      chk(nm, {27'h0, e}, {27'h0, lock_engaged, safety_output_first, solenoid_energize, led_green, led_red});
   endtask
   task automatic cycle_power();
      supply_ok <= 1'h0;
      wcyc(8);
      supply_ok <= 1'h1;
      wcyc(8);
   endtask
   initial begin
      rst = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h0; pwdata = 32'h0;
      supply_ok = 1'h1; actuator_detect = 1'h0; actuator_code = 16'h0; guard_closed = 1'h1;
      selector_ok = 1'h1; want_open = 1'h0; power_to_lock = 1'h0;
      wcyc(16);
      rst <= 1'h0;
      rd("config", REG_CONFIG, 32'h0, 1'h0);
      rd("enable", REG_ENABLE, 32'h0, 1'h0);
      rd("clear", REG_CLEAR, 32'h0, 1'h0);
      wr(REG_STATUS, 32'h1f);
      rd("status", REG_STATUS, 32'h0, 1'h0);
      rd("unmapped", 8'h20, 32'h0, 1'h1);
      $display("registers done");
      actuator_code <= STANDARD_CODE;
      actuator_detect <= 1'h1;
      wcyc(12);
      pins("standard", 5'h1a);
      chk("yellow", 32'h1, {31'h0, led_yellow});
      want_open <= 1'h1;
      wcyc(12);
      pins("released", 5'h06);
      want_open <= 1'h0;
      wcyc(12);
      pins("relocked", 5'h1a);
      wr(REG_CONFIG, 32'h8);
      want_open <= 1'h1;
      wcyc(12);
      pins("door dep", 5'h0e);
      guard_closed <= 1'h0;
      wcyc(12);
      pins("door open", 5'h06);
      wr(REG_CONFIG, 32'h4);
      guard_closed <= 1'h1;
      power_to_lock <= 1'h1;
      want_open <= 1'h0;
      wcyc(12);
      pins("p2l locked", 5'h1e);
      want_open <= 1'h1;
      wcyc(12);
      pins("p2l open", 5'h02);
      power_to_lock <= 1'h0;
      want_open <= 1'h0;
      wr(REG_CONFIG, 32'h0);
      wr(REG_CLEAR, 32'h1f);
      $display("lock modes done");
      selector_ok <= 1'h0;
      wcyc(12);
      pins("selector", 5'h02);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd("status", REG_STATUS, 32'h18, 1'h0);
      wr(REG_ENABLE, 32'h10);
      wcyc(2);
      chk("irq on", 32'h1, {31'h0, irq});
      selector_ok <= 1'h1;
      wr(REG_CLEAR, 32'h10);
      wcyc(2);
      chk("irq off", 32'h0, {31'h0, irq});
      $display("selector done");
      wr(REG_CONFIG, 32'h3);
      actuator_detect <= 1'h0;
      cycle_power();
      actuator_code <= 16'h1234;
      actuator_detect <= 1'h1;
      wcyc(12);
      rd("pairing", REG_STATE, 32'h31, 1'h0);
      pins("pairing", 5'h01);
      wcyc(TR * TK + 8);
      rd("off req", REG_STATE, 32'h33, 1'h0);
      supply_ok <= 1'h0;
      wcyc(8);
      rd("confirm", REG_STATE, 32'h32, 1'h0);
      supply_ok <= 1'h1;
      wcyc(12);
      rd("learned", REG_STATE, 32'h38, 1'h0);
      rd("code", REG_CODE, 32'h11234, 1'h0);
      chk("inhibit", 32'h2, {30'h0, lock_engaged, safety_output_first});
      wcyc(IH * TK / 2);
      cycle_power();
      wcyc(IH * TK / 2);
      chk("restart", 32'h2, {30'h0, lock_engaged, safety_output_first});
      wcyc(IH * TK + 12);
      pins("enabled", 5'h1a);
      actuator_code <= STANDARD_CODE;
      wcyc(12);
      chk("old code", 32'h0, {30'h0, lock_engaged, safety_output_first});
      $display("pairing done");
      wr(REG_CONFIG, 32'h1);
      actuator_detect <= 1'h0;
      cycle_power();
      actuator_code <= 16'h0bad;
      actuator_detect <= 1'h1;
      wcyc(12);
      rd("permanent", REG_STATE, 32'h30, 1'h0);
      wr(REG_CONFIG, 32'h3);
      actuator_detect <= 1'h0;
      cycle_power();
      actuator_detect <= 1'h1;
      wcyc((TR + PO) * TK + 16);
      rd("aborted", REG_STATE, 32'h36, 1'h0);
      chk("channels", 32'h0, {31'h0, channels_differ});
      $display("abort done");
      print_verdict();
   end
endmodule
